// ===== scpm_cfg.svh
// Constants for the scanner port, mode and clock command block
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH

// ************************************************************
// Character codes
// ************************************************************
`define SCPM_CH_0 8'h30
`define SCPM_CH_9 8'h39
`define SCPM_CH_A 8'h41
`define SCPM_CH_Z 8'h5a
`define SCPM_CH_EXEC 8'h58
`define SCPM_CH_GET 8'h47
`define SCPM_CH_PORT 8'h4f
`define SCPM_CH_PROG 8'h50
`define SCPM_CH_ALARM 8'h51
`define SCPM_CH_RESET 8'h52
`define SCPM_CH_TIME 8'h53

// ************************************************************
// Argument limits and codes
// ************************************************************
`define SCPM_OCT_MAX_MSD 4'h3
`define SCPM_OCT_DIGIT_MAX 4'h7
`define SCPM_PORT_MAX_DIGITS 3'h3
`define SCPM_TIME_MAX_DIGITS 3'h6
`define SCPM_ARG_INSPECT_ON 4'h3
`define SCPM_ARG_INSPECT_OFF 4'h4
`define SCPM_ARG_STATUS 4'h4
`define SCPM_BUF_MIN 7'h01
`define SCPM_BUF_MAX 7'h4b
`define SCPM_HOUR_MAX 7'h17
`define SCPM_MINSEC_MAX 7'h3b
`define SCPM_PORT_RESET 8'h00

// ************************************************************
// Timing
// ************************************************************
`define SCPM_CLK_NS 40
`define SCPM_SEC_NS 1000000000
`define SCPM_ALARM_MIN_NS 10000

`endif

// ===== scpm_pkg.sv
// Types for the scanner port, mode and clock command block
package scpm_pkg;

  typedef enum logic [1:0] {
    SCPM_STEP = 2'h0,
    SCPM_SINGLE = 2'h1,
    SCPM_CONT = 2'h2
  } scpm_scan_t;

  typedef enum logic [5:0] {
    SCPM_CMD_NONE = 6'h01,
    SCPM_CMD_PORT = 6'h02,
    SCPM_CMD_PROG = 6'h04,
    SCPM_CMD_ALARM = 6'h08,
    SCPM_CMD_RESET = 6'h10,
    SCPM_CMD_TIME = 6'h20
  } scpm_cmd_t;

  typedef struct packed {
    logic port_v;
    logic [7:0] port_val;
    logic mode_v;
    logic [3:0] mode_arg;
    logic alarm_v;
    logic [20:0] alarm;
    logic time_v;
    logic [20:0] tod;
    logic chrst;
    logic bufclr;
    logic [6:0] bufidx;
    logic stat;
    logic err;
  } scpm_pend_t;

endpackage

// ===== scpm_mod_cnt.sv
// Loadable modulo counter for one time-of-day field
`timescale 1ns/1ps
`default_nettype none
module scpm_mod_cnt #(
  parameter int W = 6,
  parameter logic [W-1:0] MAX = 6'h3b
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic inc,
  output logic [W-1:0] value,
  output logic wrap
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign wrap = inc && (cnt_q == MAX);
  assign value = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (wrap) begin
      cnt_d = '0;
    end else if (inc) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ===== scpm_top.sv
// Command interpreter for port output, scan mode, alarm, reset and time of day
`timescale 1ns/1ps
`default_nettype none
`include "scpm_cfg.svh"
module scpm_top #(
  parameter int TICK_CYCLES = `SCPM_SEC_NS / `SCPM_CLK_NS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] CHAR_DATA,
  input wire logic CHAR_STB,
  input wire logic BUS_CLEAR,
  input wire logic [7:0] DIG_IN,
  output logic [7:0] DIG_OUT,
  output scpm_pkg::scpm_scan_t SCAN_MODE,
  output logic INSPECT,
  output logic CONT_LED,
  output logic SERIAL_OUT_N,
  output logic CH_RESET,
  output logic BUF_CLEAR,
  output logic [6:0] BUF_INDEX,
  output logic STAT_VALID,
  output logic [7:0] STAT_IN,
  output logic [7:0] STAT_OUT,
  output logic CMD_ERROR,
  output logic [4:0] TOD_HOURS,
  output logic [5:0] TOD_MINUTES,
  output logic [5:0] TOD_SECONDS
);
  import scpm_pkg::*;

  localparam int ALARM_CYCLES = (`SCPM_ALARM_MIN_NS / `SCPM_CLK_NS) + 1;
  localparam int PW = $clog2(TICK_CYCLES);

  function automatic logic [6:0] bcd2bin(input logic [3:0] t, input logic [3:0] o);
    return ({3'h0, t} * 7'h0a) + {3'h0, o};
  endfunction

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  logic [7:0] din_s1_q;
  logic [7:0] din_s2_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= DIG_IN;
      din_s2_q <= din_s1_q;
    end
  end

  // ************************************************************
  // Parser
  // ************************************************************
  scpm_cmd_t cmd_q, cmd_d;
  logic [23:0] acc_q, acc_d;
  logic [2:0] ndig_q, ndig_d;
  scpm_pend_t pend_q, pend_d, pend_now;
  logic is_digit, is_letter, commit;
  logic [3:0] d0, d1, d2, d3, d4, d5;
  logic [6:0] hh, mm, ss, rv;
  logic time_ok;

  always_comb begin
    is_digit = (CHAR_DATA >= `SCPM_CH_0) && (CHAR_DATA <= `SCPM_CH_9);
    is_letter = (CHAR_DATA >= `SCPM_CH_A) && (CHAR_DATA <= `SCPM_CH_Z);
    commit = CHAR_STB && (CHAR_DATA == `SCPM_CH_EXEC) && !BUS_CLEAR;
    {d5, d4, d3, d2, d1, d0} = acc_q;
    hh = bcd2bin(d5, d4);
    mm = bcd2bin(d3, d2);
    ss = bcd2bin(d1, d0);
    rv = bcd2bin(d1, d0);
    time_ok = (ndig_q != 3'h0) && (ndig_q <= `SCPM_TIME_MAX_DIGITS) &&
              (hh <= `SCPM_HOUR_MAX) && (mm <= `SCPM_MINSEC_MAX) && (ss <= `SCPM_MINSEC_MAX);
    cmd_d = cmd_q;
    acc_d = acc_q;
    ndig_d = ndig_q;
    pend_now = pend_q;
    if (CHAR_STB && is_letter) begin
      // Each command closes when the next letter or the execute character arrives
      case (cmd_q)
        SCPM_CMD_PORT: begin
          if ((ndig_q != 3'h0) && (ndig_q <= `SCPM_PORT_MAX_DIGITS) &&
              (d2 <= `SCPM_OCT_MAX_MSD) && (d1 <= `SCPM_OCT_DIGIT_MAX) &&
              (d0 <= `SCPM_OCT_DIGIT_MAX)) begin
            pend_now.port_v = 1'b1;
            pend_now.port_val = {d2[1:0], d1[2:0], d0[2:0]};
          end else begin
            pend_now.err = 1'b1;
          end
        end
        SCPM_CMD_PROG: begin
          if ((ndig_q == 3'h1) && (d0 <= `SCPM_ARG_INSPECT_OFF)) begin
            pend_now.mode_v = 1'b1;
            pend_now.mode_arg = d0;
          end else begin
            pend_now.err = 1'b1;
          end
        end
        SCPM_CMD_ALARM: begin
          if (time_ok) begin
            pend_now.alarm_v = 1'b1;
            pend_now.alarm = {hh[4:0], mm[5:0], ss[5:0], 4'h0};
          end else begin
            pend_now.err = 1'b1;
          end
        end
        SCPM_CMD_TIME: begin
          if (time_ok) begin
            pend_now.time_v = 1'b1;
            pend_now.tod = {hh[4:0], mm[5:0], ss[5:0], 4'h0};
          end else begin
            pend_now.err = 1'b1;
          end
        end
        SCPM_CMD_RESET: begin
          if (ndig_q == 3'h0) begin
            pend_now.chrst = 1'b1;
          end else if ((ndig_q <= 3'h2) && (rv >= `SCPM_BUF_MIN) && (rv <= `SCPM_BUF_MAX)) begin
            pend_now.bufclr = 1'b1;
            pend_now.bufidx = rv;
          end else begin
            pend_now.err = 1'b1;
          end
        end
        SCPM_CMD_NONE: begin
        end
        default: begin
        end
      endcase
      acc_d = 24'h000000;
      ndig_d = 3'h0;
      case (CHAR_DATA)
        `SCPM_CH_PORT: cmd_d = SCPM_CMD_PORT;
        `SCPM_CH_PROG: cmd_d = SCPM_CMD_PROG;
        `SCPM_CH_ALARM: cmd_d = SCPM_CMD_ALARM;
        `SCPM_CH_RESET: cmd_d = SCPM_CMD_RESET;
        `SCPM_CH_TIME: cmd_d = SCPM_CMD_TIME;
        default: cmd_d = SCPM_CMD_NONE;
      endcase
      // Status request is a two-character command, caught by the letter tracker below from the previous letter
    end else if (CHAR_STB && is_digit) begin
      // Separators are skipped, so digits alone fill the fields from the right
      acc_d = {acc_q[19:0], CHAR_DATA[3:0]};
      ndig_d = (ndig_q == 3'h7) ? ndig_q : ndig_q + 3'h1;
    end
    pend_d = pend_now;
    if (commit) begin
      cmd_d = SCPM_CMD_NONE;
      pend_d = '0;
    end
    if (BUS_CLEAR) begin
      cmd_d = SCPM_CMD_NONE;
      acc_d = 24'h000000;
      ndig_d = 3'h0;
      pend_d = '0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_q <= SCPM_CMD_NONE;
      acc_q <= 24'h000000;
      ndig_q <= 3'h0;
      pend_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      acc_q <= acc_d;
      ndig_q <= ndig_d;
      pend_q <= pend_d;
    end
  end

  // ************************************************************
  // Status request letter tracker
  // ************************************************************
  logic get_q, get_d, stat_arm_q, stat_arm_d;
  logic port_status_with_prefix;

  always_comb begin
    get_d = get_q;
    stat_arm_d = stat_arm_q;
    if (CHAR_STB && is_letter) begin
      get_d = (CHAR_DATA == `SCPM_CH_GET);
    end else if (CHAR_STB && is_digit) begin
      stat_arm_d = stat_arm_q | (get_q && (CHAR_DATA[3:0] == `SCPM_ARG_STATUS));
      get_d = 1'b0;
    end
    port_status_with_prefix = commit && stat_arm_q;
    if (commit || BUS_CLEAR) begin
      get_d = 1'b0;
      stat_arm_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      get_q <= 1'b0;
      stat_arm_q <= 1'b0;
    end else begin
      get_q <= get_d;
      stat_arm_q <= stat_arm_d;
    end
  end

  // ************************************************************
  // Execution state
  // ************************************************************
  logic [7:0] dout_q, dout_d, sin_q, sin_d, sout_q, sout_d;
  scpm_scan_t mode_q, mode_d, prev_q, prev_d;
  logic insp_q, insp_d, armed_q, armed_d;
  logic [16:0] alarm_q, alarm_d;
  logic chrst_q, chrst_d, bclr_q, bclr_d, sv_q, sv_d, err_q, err_d;
  logic [6:0] bidx_q, bidx_d;
  logic inspect_on, inspect_off_restore;

  always_comb begin
    dout_d = dout_q;
    mode_d = mode_q;
    prev_d = prev_q;
    insp_d = insp_q;
    armed_d = armed_q;
    alarm_d = alarm_q;
    bidx_d = bidx_q;
    sin_d = sin_q;
    sout_d = sout_q;
    chrst_d = 1'b0;
    bclr_d = 1'b0;
    sv_d = 1'b0;
    err_d = 1'b0;
    inspect_on = pend_now.mode_v && (pend_now.mode_arg == `SCPM_ARG_INSPECT_ON);
    inspect_off_restore = pend_now.mode_v && (pend_now.mode_arg == `SCPM_ARG_INSPECT_OFF);
    if (commit) begin
      if (pend_now.port_v) begin
        dout_d = pend_now.port_val;
      end
      if (inspect_on) begin
        if (!insp_q) begin
          prev_d = mode_q;
        end
        insp_d = 1'b1;
      end else if (inspect_off_restore) begin
        insp_d = 1'b0;
        mode_d = insp_q ? prev_q : mode_q;
      end else if (pend_now.mode_v) begin
        mode_d = scpm_scan_t'(pend_now.mode_arg[1:0]);
        prev_d = scpm_scan_t'(pend_now.mode_arg[1:0]);
      end
      if (pend_now.alarm_v) begin
        alarm_d = pend_now.alarm[20:4];
        armed_d = 1'b1;
      end
      chrst_d = pend_now.chrst;
      bclr_d = pend_now.bufclr;
      if (pend_now.bufclr) begin
        bidx_d = pend_now.bufidx;
      end
      err_d = pend_now.err;
      if (port_status_with_prefix) begin
        sv_d = 1'b1;
        sin_d = din_s2_q;
        sout_d = pend_now.port_v ? pend_now.port_val : dout_q;
      end
    end
    if (BUS_CLEAR) begin
      dout_d = `SCPM_PORT_RESET;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dout_q <= `SCPM_PORT_RESET;
      mode_q <= SCPM_STEP;
      prev_q <= SCPM_STEP;
      insp_q <= 1'b0;
      armed_q <= 1'b0;
      alarm_q <= 17'h00000;
      bidx_q <= 7'h00;
      sin_q <= 8'h00;
      sout_q <= 8'h00;
      chrst_q <= 1'b0;
      bclr_q <= 1'b0;
      sv_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      mode_q <= mode_d;
      prev_q <= prev_d;
      insp_q <= insp_d;
      armed_q <= armed_d;
      alarm_q <= alarm_d;
      bidx_q <= bidx_d;
      sin_q <= sin_d;
      sout_q <= sout_d;
      chrst_q <= chrst_d;
      bclr_q <= bclr_d;
      sv_q <= sv_d;
      err_q <= err_d;
    end
  end

  // ************************************************************
  // Time of day and alarm pulse
  // ************************************************************
  logic [PW-1:0] pre_q, pre_d;
  logic tick, chk_q, chk_d, tod_load, s_wrap, m_wrap;
  logic [8:0] pcnt_q, pcnt_d;
  logic [4:0] tod_h;
  logic [5:0] tod_m, tod_s;

  assign tod_load = commit && pend_now.time_v;
  assign tick = (pre_q == PW'(TICK_CYCLES - 1));

  scpm_mod_cnt #(.W(6), .MAX(6'h3b)) u_sec (
    .clk(CLK), .sys_rst(SYS_RST), .load(tod_load), .load_val(pend_now.tod[9:4]),
    .inc(tick), .value(tod_s), .wrap(s_wrap)
  );
  scpm_mod_cnt #(.W(6), .MAX(6'h3b)) u_min (
    .clk(CLK), .sys_rst(SYS_RST), .load(tod_load), .load_val(pend_now.tod[15:10]),
    .inc(s_wrap), .value(tod_m), .wrap(m_wrap)
  );
  scpm_mod_cnt #(.W(5), .MAX(5'h17)) u_hour (
    .clk(CLK), .sys_rst(SYS_RST), .load(tod_load), .load_val(pend_now.tod[20:16]),
    .inc(m_wrap), .value(tod_h), .wrap()
  );

  always_comb begin
    // Restarting the prescaler on a load keeps the first second whole
    pre_d = (tick || tod_load) ? '0 : pre_q + PW'(1);
    chk_d = tick && !tod_load;
    pcnt_d = (pcnt_q != 9'h000) ? pcnt_q - 9'h001 : 9'h000;
    // Only the cycle after a tick is examined, so a match fires once a day
    if (chk_q && armed_q && ({tod_h, tod_m, tod_s} == alarm_q)) begin
      pcnt_d = 9'(ALARM_CYCLES);
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pre_q <= '0;
      chk_q <= 1'b0;
      pcnt_q <= 9'h000;
    end else begin
      pre_q <= pre_d;
      chk_q <= chk_d;
      pcnt_q <= pcnt_d;
    end
  end

  logic ser_n_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ser_n_q <= 1'b1;
    end else begin
      ser_n_q <= (pcnt_d == 9'h000);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign DIG_OUT = dout_q;
  assign SCAN_MODE = mode_q;
  assign INSPECT = insp_q;
  assign CONT_LED = (mode_q == SCPM_CONT) && !insp_q;
  assign SERIAL_OUT_N = ser_n_q;
  assign CH_RESET = chrst_q;
  assign BUF_CLEAR = bclr_q;
  assign BUF_INDEX = bidx_q;
  assign STAT_VALID = sv_q;
  assign STAT_IN = sin_q;
  assign STAT_OUT = sout_q;
  assign CMD_ERROR = err_q;
  assign TOD_HOURS = tod_h;
  assign TOD_MINUTES = tod_m;
  assign TOD_SECONDS = tod_s;
endmodule
`default_nettype wire

// ===== scpm_properties.sv
// Concurrent checks on the ports of the scanner command block
`timescale 1ns/1ps
`default_nettype none
`include "scpm_cfg.svh"
module scpm_properties (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] CHAR_DATA,
  input wire logic CHAR_STB,
  input wire logic BUS_CLEAR,
  input wire logic [7:0] DIG_IN,
  input wire logic [7:0] DIG_OUT,
  input wire scpm_pkg::scpm_scan_t SCAN_MODE,
  input wire logic INSPECT,
  input wire logic CONT_LED,
  input wire logic SERIAL_OUT_N,
  input wire logic CH_RESET,
  input wire logic BUF_CLEAR,
  input wire logic [6:0] BUF_INDEX,
  input wire logic STAT_VALID,
  input wire logic [7:0] STAT_IN,
  input wire logic [7:0] STAT_OUT,
  input wire logic CMD_ERROR,
  input wire logic [4:0] TOD_HOURS,
  input wire logic [5:0] TOD_MINUTES,
  input wire logic [5:0] TOD_SECONDS
);
  import scpm_pkg::*;
  logic x_stb;
  logic [8:0] low_q;
  logic [8:0] low_d;
  assign x_stb = CHAR_STB && (CHAR_DATA == `SCPM_CH_EXEC);
  // Counts low cycles of the alarm line so the width is checked as one figure
  always_comb begin
    low_d = SERIAL_OUT_N ? 9'h000 : low_q + 9'h001;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_q <= 9'h000;
    end else begin
      low_q <= low_d;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence idle_s;
    !x_stb && !BUS_CLEAR;
  endsequence
  sequence pulse_end_s;
    $rose(SERIAL_OUT_N);
  endsequence
  cont_led_a: assert property (CONT_LED == (SCAN_MODE == SCPM_CONT && !INSPECT))
    else $error("continuous indicator wrong");
  port_clear_a: assert property (BUS_CLEAR |=> DIG_OUT == `SCPM_PORT_RESET)
    else $error("port not cleared");
  hold_exec_a: assert property (idle_s |=> $stable(DIG_OUT) && $stable(SCAN_MODE))
    else $error("state changed without execute");
  alarm_width_a: assert property (pulse_end_s |-> low_q == 9'h0fb)
    else $error("alarm pulse width wrong");
  ch_reset_a: assert property (CH_RESET |-> $past(x_stb))
    else $error("channel reset without execute");
  stat_port_a: assert property (STAT_VALID |-> STAT_OUT == DIG_OUT && $past(x_stb))
    else $error("status output mismatch");
  buf_range_a: assert property (BUF_CLEAR |-> BUF_INDEX >= 7'h01 && BUF_INDEX <= 7'h4b)
    else $error("buffer index out of range");
  sec_step_a: assert property (($changed(TOD_SECONDS) && !$past(x_stb)) |->
    TOD_SECONDS == ($past(TOD_SECONDS) == 6'h3b ? 6'h00 : $past(TOD_SECONDS) + 6'h01))
    else $error("seconds stepped wrongly");
endmodule
bind scpm_top scpm_properties u_props (.CLK(CLK), .SYS_RST(SYS_RST), .CHAR_DATA(CHAR_DATA),
  .CHAR_STB(CHAR_STB), .BUS_CLEAR(BUS_CLEAR), .DIG_IN(DIG_IN), .DIG_OUT(DIG_OUT),
  .SCAN_MODE(SCAN_MODE), .INSPECT(INSPECT), .CONT_LED(CONT_LED), .SERIAL_OUT_N(SERIAL_OUT_N),
  .CH_RESET(CH_RESET), .BUF_CLEAR(BUF_CLEAR), .BUF_INDEX(BUF_INDEX), .STAT_VALID(STAT_VALID),
  .STAT_IN(STAT_IN), .STAT_OUT(STAT_OUT), .CMD_ERROR(CMD_ERROR), .TOD_HOURS(TOD_HOURS),
  .TOD_MINUTES(TOD_MINUTES), .TOD_SECONDS(TOD_SECONDS));
`default_nettype wire

// ===== scpm_ctrl_model.sv
// Bus controller model that streams command strings one character a cycle
`timescale 1ns/1ps
`default_nettype none
module scpm_ctrl_model (
  input wire logic clk,
  output logic [7:0] chr,
  output logic stb,
  output logic clr
);
  initial begin
    chr = 8'h00;
    stb = 1'b0;
    clr = 1'b0;
  end
  // Callers pass port values inside or outside the octal range 0 to 377, and colons at will
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      #1;
      chr = s[i];
      stb = 1'b1;
    end
    @(posedge clk);
    #1;
    stb = 1'b0;
    // Released lines must not keep showing the last character
    chr = ~chr;
  endtask
  task automatic dev_clear();
    @(posedge clk);
    #1;
    clr = 1'b1;
    @(posedge clk);
    #1;
    clr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== scpm_top_tb.sv
// Self-checking testbench for the scanner command block
`timescale 1ns/1ps
`default_nettype none
module scpm_top_tb;
  import scpm_pkg::*;
  logic clk, rst, stb, clr, cont, ser_n, chrst, bufclr, statv, err, insp;
  logic [7:0] chr, din, dout, stin, stout;
  logic [6:0] bidx;
  logic [4:0] hh;
  logic [5:0] mm, ss;
  scpm_scan_t mode;
  int mismatches, cmp_count, cycles;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  scpm_ctrl_model ctrl (.clk(clk), .chr(chr), .stb(stb), .clr(clr));
  // Short prescaler keeps alarm scenarios within a few hundred cycles
  scpm_top #(.TICK_CYCLES(20)) DUT (.CLK(clk), .SYS_RST(rst), .CHAR_DATA(chr), .CHAR_STB(stb),
    .BUS_CLEAR(clr), .DIG_IN(din), .DIG_OUT(dout), .SCAN_MODE(mode), .INSPECT(insp),
    .CONT_LED(cont), .SERIAL_OUT_N(ser_n), .CH_RESET(chrst), .BUF_CLEAR(bufclr),
    .BUF_INDEX(bidx), .STAT_VALID(statv), .STAT_IN(stin), .STAT_OUT(stout), .CMD_ERROR(err),
    .TOD_HOURS(hh), .TOD_MINUTES(mm), .TOD_SECONDS(ss));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic wait_alarm(input int lim, input logic low);
    int n;
    n = 0;
    while (ser_n === 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, ser_n}, {7'h0, !low});
  endtask
  task automatic pulse_width();
    int n;
    n = 0;
    while (ser_n === 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'hfb);
  endtask
  task automatic t_port();
    chk(dout, 8'h00);
    ctrl.send("O377X");
    chk(dout, 8'hff);
    ctrl.send("O077G4X");
    chk(dout, 8'h3f);
    chk({7'h0, statv}, 8'h01);
    chk(stout, 8'h3f);
    chk(stin, 8'h5a);
    din = 8'hc3;
    ctrl.send("G4X");
    chk(stin, 8'hc3);
    chk(stout, 8'h3f);
    ctrl.send("O400X");
    chk({7'h0, err}, 8'h01);
    ctrl.send("O78X");
    chk(dout, 8'h3f);
    ctrl.send("O12");
    ctrl.dev_clear();
    chk(dout, 8'h00);
    ctrl.send("X");
    chk(dout, 8'h00);
  endtask
  task automatic t_mode();
    for (int m = 0; m < 3; m++) begin
      ctrl.send($sformatf("P%0dX", m));
      chk({6'h0, mode}, 8'(m));
      chk({7'h0, cont}, 8'(m == 2));
    end
    ctrl.send("P3X");
    chk({7'h0, insp}, 8'h01);
    chk({7'h0, cont}, 8'h00);
    ctrl.send("P4X");
    chk({6'h0, mode}, 8'h02);
    chk({7'h0, insp}, 8'h00);
    ctrl.send("P5X");
    chk({7'h0, err}, 8'h01);
    chk({6'h0, mode}, 8'h02);
  endtask
  task automatic t_rcmd();
    ctrl.send("RX");
    chk({7'h0, chrst}, 8'h01);
    ctrl.send("R75X");
    chk({bufclr, bidx}, 8'hcb);
    ctrl.send("R1X");
    chk({bufclr, bidx}, 8'h81);
    ctrl.send("R76X");
    chk({bufclr, 6'h0, err}, 8'h01);
  endtask
  task automatic t_time();
    ctrl.send("D2S17:00:00X");
    chk({3'h0, hh}, 8'h11);
    chk({mm, 2'h0}, 8'h00);
    ctrl.send("S17X");
    chk({3'h0, hh}, 8'h00);
    chk({2'h0, ss}, 8'h11);
    chk({2'h0, mm}, 8'h00);
  endtask
  task automatic t_alarm();
    ctrl.send("S14:13X");
    ctrl.send("Q1415X");
    wait_alarm(100, 1'b1);
    chk({2'h0, mm}, 8'h0e);
    chk({2'h0, ss}, 8'h0f);
    pulse_width();
    ctrl.send("S1414X");
    wait_alarm(100, 1'b1);
    pulse_width();
    ctrl.send("Q14:15:00X");
    ctrl.send("S14:14X");
    wait_alarm(80, 1'b0);
    ctrl.send("S14:14:59X");
    wait_alarm(100, 1'b1);
    chk({3'h0, hh}, 8'h0e);
    pulse_width();
  endtask
  initial begin
    rst = 1'b1;
    din = 8'h5a;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_port();
    t_mode();
    t_rcmd();
    t_time();
    t_alarm();
    end_sim();
  end
endmodule
`default_nettype wire
